// ### rtl/channel_image.v
// Image of one input: reading, limit flags, wire break, not-valid
`timescale 1ns/100ps
`default_nettype none
module channel_image (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        enable,
    input  wire        strobe,
    input  wire        polarity,
    input  wire [14:0] magnitude,
    input  wire        wire_break_in,
    input  wire        high_in,
    input  wire        low_in,
    input  wire        hw_fault,
    input  wire        accept,
    output reg  [15:0] reading,
    output reg         wire_break,
    output reg         high_limit,
    output reg         low_limit,
    output reg         not_valid,
    output wire        general_fault
);
    // Data and flags captured on the same edge
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reading    <= 16'h0000;
            wire_break <= 1'b0;
            high_limit <= 1'b0;
            low_limit  <= 1'b0;
            not_valid  <= 1'b0;             // RULE6
        end else if (!enable) begin
            reading    <= 16'h0000;         // RULE19
            wire_break <= 1'b0;             // RULE3
            high_limit <= 1'b0;
            low_limit  <= 1'b0;
            not_valid  <= accept;           // RULE7 enabling setup sets it
        end else begin
            if (strobe) begin
                reading    <= {polarity, magnitude}; // RULE4 RULE22
                wire_break <= wire_break_in;  // RULE10 RULE22
                high_limit <= high_in;        // RULE11 RULE12
                low_limit  <= low_in;         // RULE13 RULE14
            end
            // Set wins over the clear by a fresh conversion
            if (accept | hw_fault)
                not_valid <= 1'b1;          // RULE7 RULE9
            else if (strobe)
                not_valid <= 1'b0;          // RULE7
        end
    end
    assign general_fault = wire_break | high_limit | low_limit | not_valid; // RULE5
endmodule // channel_image
`default_nettype wire

// ### rtl/setup_checker.v
// Validity check of one channel setup word
`timescale 1ns/100ps
`default_nettype none
`include "thermo_map.vh"
module setup_checker (
    input  wire [15:0] setup,
    output wire        valid
);
    // Spare codes in any selection field make the word invalid
    wire [2:0] format = setup[`SETUP_FORMAT_HI:`SETUP_FORMAT_LO];
    wire [3:0] kind   = setup[`SETUP_TYPE_HI:`SETUP_TYPE_LO];
    wire [2:0] filter = setup[`SETUP_FILTER_HI:`SETUP_FILTER_LO];
    assign valid = (format <= `FORMAT_LAST_VALID)   // RULE20
                 & (kind <= `TYPE_LAST_VALID)       // RULE20
                 & (filter != `FILTER_SPARE_A)      // RULE20
                 & (filter != `FILTER_SPARE_B);     // RULE20
endmodule // setup_checker
`default_nettype wire

// ### rtl/thermo_input_image_status_config.v
// Input image, status and channel setup of a four-channel input module
//
// Function
// (RULE1) Six 16-bit image words readable, five 16-bit setup words writable. Code adds a seventh image word: word 6, setup-error flags.
// (RULE2) Words 0-3 hold channel readings; valid when enabled and fault-free.
// (RULE3) Channel status only meaningful while the channel is enabled.
// (RULE4) Bit 15 of a reading is polarity, the rest is magnitude.
// (RULE5) Word 4 bits 0-4: general fault per channel and cold junction.
// (RULE6) Not-valid indication is zero after reset and in default state.
// (RULE7) Accepted valid setup sets not-valid until new conversion starts.
// (RULE8) Invalid setup leaves not-valid at zero and reports setup error.
// (RULE9) Converter hardware fault sets the channel's not-valid indication.
// (RULE10) Word 4 wire-break flags for channels and cold junction.
// (RULE11) Word 5 even bits: high-limit flags, set at range maximum.
// (RULE12) High-limit flag clears itself when value drops below maximum.
// (RULE13) Word 5 odd bits: low-limit flags, set at range minimum.
// (RULE14) Low-limit flag clears itself once back inside the range.
// (RULE15) Setup word fields: enable, format, type, units, open, filter.
// (RULE16) All-zero setup word selects every default.
// (RULE17) Setup words are writable and read back.
// (RULE18) Word 4 bit 0 enables five-minute periodic calibration.
// (RULE19) Only enabled channels scanned; disabled channel reading is zero.
// (RULE20) Spare codes in any selection field flag a setup error.
// (RULE21) Reserved bits of status words read zero.
// (RULE22) Flags and reading of a channel update together.
`timescale 1ns/100ps
`default_nettype none
`include "thermo_map.vh"
module thermo_input_image_status_config #(
    parameter         CAL_W             = 33,
    parameter [32:0]  CAL_PERIOD_CYCLES = `CAL_PERIOD_CYCLES
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    input  wire        conv_strobe,
    input  wire [2:0]  conv_channel,
    input  wire        conv_polarity,
    input  wire [14:0] conv_magnitude,
    input  wire        conv_wire_break,
    input  wire        conv_high_limit,
    input  wire        conv_low_limit,
    input  wire [4:0]  hw_fault,
    output wire [3:0]  channel_enable,
    output reg  [63:0] active_setup,
    output reg  [3:0]  setup_load,
    output reg         cal_request,
    output reg  [3:0]  setup_error
);

    //----------
    // Declarations
    //----------
    localparam [2:0] COLD_JUNCTION = 3'h4;

    reg  [15:0]      setup [0:3];
    reg              cal_enable;
    reg              wr_pending;
    reg              wr_region;
    reg  [3:0]       wr_index;
    reg  [15:0]      next_rdata;
    reg  [CAL_W-1:0] cal_count;
    reg  [3:0]       accept;
    reg  [3:0]       reject;
    wire             addr_phase;
    wire             rd_region;
    wire [3:0]       rd_index;
    wire [3:0]       setup_valid;
    wire [3:0]       write_hit;
    wire [15:0]      reading [0:3];
    wire [4:0]       wire_break;
    wire [4:0]       high_limit;
    wire [4:0]       low_limit;
    wire [4:0]       general_fault;
    wire [4:0]       strobe_sel;
    wire [4:0]       image_enable;
    wire [4:0]       image_accept;
    wire [15:0]      fault_word;
    wire [15:0]      range_word;
    integer          i;

    // Index of a setup word for a given channel
    function [3:0] setup_index;
        input integer ch;
        begin
            setup_index = ch[3:0];
        end
    endfunction

    //----------
    // Bus slave: zero wait states, always OKAY
    //----------
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign addr_phase = hsel & hready & htrans[1];
    assign rd_region  = haddr[`REGION_BIT];
    assign rd_index   = haddr[5:2];

    // Capture the address phase of a write
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending <= 1'b0;
            wr_region  <= 1'b0;
            wr_index   <= 4'h0;
        end else begin
            wr_pending <= addr_phase & hwrite;
            if (addr_phase) begin
                wr_region <= rd_region;
                wr_index  <= rd_index;
            end
        end
    end

    // Read data loaded at the address phase edge
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (addr_phase & ~hwrite) begin
            hrdata <= {16'h0000, next_rdata}; // RULE1
        end
    end

    //----------
    // Status words
    //----------
    // Reserved bits tied to zero
    assign fault_word = {3'h0, wire_break, 3'h0, general_fault}; // RULE5 RULE10 RULE21
    // Channel c: low at bit 15-2c, high at bit 14-2c
    assign range_word = {low_limit[0], high_limit[0],
                         low_limit[1], high_limit[1],
                         low_limit[2], high_limit[2],
                         low_limit[3], high_limit[3],
                         low_limit[4], high_limit[4],
                         6'h00};                      // RULE11 RULE13 RULE21

    // Read multiplexer; unmapped words read zero
    always @* begin
        next_rdata = 16'h0000;
        if (rd_region == `REGION_IMAGE) begin
            case (rd_index)
                `IDX_CHANNEL0_READING:      next_rdata = reading[0]; // RULE2
                `IDX_CHANNEL1_READING:      next_rdata = reading[1];
                `IDX_CHANNEL2_READING:      next_rdata = reading[2];
                `IDX_CHANNEL3_READING:      next_rdata = reading[3];
                `IDX_FAULT_AND_BREAK_FLAGS: next_rdata = fault_word;
                `IDX_RANGE_LIMIT_FLAGS:     next_rdata = range_word;
                `IDX_SETUP_ERROR_FLAGS:     next_rdata = {12'h000, setup_error};
                default:                    next_rdata = 16'h0000;
            endcase
        end else begin
            case (rd_index)
                `IDX_CHANNEL0_SETUP:     next_rdata = setup[0]; // RULE17
                `IDX_CHANNEL1_SETUP:     next_rdata = setup[1];
                `IDX_CHANNEL2_SETUP:     next_rdata = setup[2];
                `IDX_CHANNEL3_SETUP:     next_rdata = setup[3];
                `IDX_PERIODIC_CAL_SETUP: next_rdata = {15'h0000, cal_enable}; // RULE18
                default:                 next_rdata = 16'h0000;
            endcase
        end
    end

    //----------
    // Setup words and their validation
    //----------
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : check
            setup_checker u_check (
                .setup (hwdata[15:0]),
                .valid (setup_valid[g])
            );
            assign write_hit[g] = wr_pending & (wr_region == `REGION_SETUP)
                                & (wr_index == setup_index(g));
        end
    endgenerate

    // Accepted and rejected writes per channel
    always @* begin
        accept = 4'h0;
        reject = 4'h0;
        for (i = 0; i < 4; i = i + 1) begin
            accept[i] = write_hit[i] & setup_valid[i];  // RULE7
            reject[i] = write_hit[i] & ~setup_valid[i]; // RULE8 RULE20
        end
    end

    // Stored word reads back as written; active copy only if valid
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (i = 0; i < 4; i = i + 1)
                setup[i] <= `SETUP_RESET;              // RULE16
            active_setup <= {4{`SETUP_RESET}};         // RULE16
            setup_error  <= 4'h0;
            setup_load   <= 4'h0;
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                if (write_hit[i])
                    setup[i] <= hwdata[15:0];          // RULE17
                if (accept[i]) begin
                    active_setup[i*16 +: 16] <= hwdata[15:0]; // RULE15
                    setup_error[i] <= 1'b0;
                end else if (reject[i]) begin
                    setup_error[i] <= 1'b1;            // RULE8 RULE20
                end
            end
            setup_load <= accept;
        end
    end

    // Calibration enable; reserved bits not stored
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cal_enable <= 1'b0;
        end else if (wr_pending & (wr_region == `REGION_SETUP)
                     & (wr_index == `IDX_PERIODIC_CAL_SETUP)) begin
            cal_enable <= hwdata[`CAL_ENABLE_BIT];     // RULE18
        end
    end

    //----------
    // Periodic calibration timer
    //----------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cal_count   <= {CAL_W{1'b0}};
            cal_request <= 1'b0;
        end else if (cal_enable & (|channel_enable)) begin
            if (cal_count == CAL_PERIOD_CYCLES[CAL_W-1:0] - 1'b1) begin
                cal_count   <= {CAL_W{1'b0}};
                cal_request <= 1'b1;                   // RULE18
            end else begin
                cal_count   <= cal_count + 1'b1;
                cal_request <= 1'b0;
            end
        end else begin
            cal_count   <= {CAL_W{1'b0}};
            cal_request <= 1'b0;
        end
    end

    //----------
    // Channel and cold junction images
    //----------
    generate
        for (g = 0; g < 4; g = g + 1) begin : en
            assign channel_enable[g] = active_setup[g*16 + `SETUP_ENABLE_BIT]; // RULE19
            assign image_enable[g]   = channel_enable[g];
            assign image_accept[g]   = accept[g] & hwdata[`SETUP_ENABLE_BIT];
        end
    endgenerate
    assign image_enable[4] = 1'b1;
    assign image_accept[4] = 1'b0;

    generate
        for (g = 0; g < 5; g = g + 1) begin : img
            // Converter results only reach enabled channels
            assign strobe_sel[g] = conv_strobe & ({1'b0, conv_channel} == setup_index(g)); // RULE19
            if (g < 4) begin : data
                channel_image u_image (
                    .hclk          (hclk),
                    .hresetn       (hresetn),
                    .enable        (image_enable[g]),
                    .strobe        (strobe_sel[g]),
                    .polarity      (conv_polarity),
                    .magnitude     (conv_magnitude),
                    .wire_break_in (conv_wire_break),
                    .high_in       (conv_high_limit),
                    .low_in        (conv_low_limit),
                    .hw_fault      (hw_fault[g]),
                    .accept        (image_accept[g]),
                    .reading       (reading[g]),
                    .wire_break    (wire_break[g]),
                    .high_limit    (high_limit[g]),
                    .low_limit     (low_limit[g]),
                    .not_valid     (),
                    .general_fault (general_fault[g])
                );
            end else begin : cold
                channel_image u_image (
                    .hclk          (hclk),
                    .hresetn       (hresetn),
                    .enable        (image_enable[g]),
                    .strobe        (strobe_sel[g]),
                    .polarity      (conv_polarity),
                    .magnitude     (conv_magnitude),
                    .wire_break_in (conv_wire_break),
                    .high_in       (conv_high_limit),
                    .low_in        (conv_low_limit),
                    .hw_fault      (hw_fault[g]),
                    .accept        (image_accept[g]),
                    .reading       (),
                    .wire_break    (wire_break[g]),
                    .high_limit    (high_limit[g]),
                    .low_limit     (low_limit[g]),
                    .not_valid     (),
                    .general_fault (general_fault[g])
                );
            end
        end
    endgenerate

endmodule // thermo_input_image_status_config
`default_nettype wire

// ### rtl/thermo_map.vh
// Register map, field positions, reset values and timing counts
`ifndef THERMO_MAP_VH
`define THERMO_MAP_VH
// Word indices; byte address is four times the index, plus 64 for setup words
`define IDX_CHANNEL0_READING      4'h0
`define IDX_CHANNEL1_READING      4'h1
`define IDX_CHANNEL2_READING      4'h2
`define IDX_CHANNEL3_READING      4'h3
`define IDX_FAULT_AND_BREAK_FLAGS 4'h4
`define IDX_RANGE_LIMIT_FLAGS     4'h5
`define IDX_SETUP_ERROR_FLAGS     4'h6
`define IDX_CHANNEL0_SETUP        4'h0
`define IDX_CHANNEL1_SETUP        4'h1
`define IDX_CHANNEL2_SETUP        4'h2
`define IDX_CHANNEL3_SETUP        4'h3
`define IDX_PERIODIC_CAL_SETUP    4'h4
// Region select, haddr bit 6: image words or setup words
`define REGION_BIT                6
`define REGION_IMAGE              1'b0
`define REGION_SETUP              1'b1
// Channel setup word fields
`define SETUP_ENABLE_BIT          15
`define SETUP_FORMAT_HI           14
`define SETUP_FORMAT_LO           12
`define SETUP_TYPE_HI             11
`define SETUP_TYPE_LO             8
`define SETUP_FILTER_HI           2
`define SETUP_FILTER_LO           0
`define FORMAT_LAST_VALID         3'h4
`define TYPE_LAST_VALID           4'ha
`define FILTER_SPARE_A            3'h2
`define FILTER_SPARE_B            3'h7
`define CAL_ENABLE_BIT            0
`define SETUP_RESET               16'h0000
// Status word fields
`define FAULT_LSB                 0
`define BREAK_LSB                 8
// Periodic calibration timing
`define CLK_HZ                    33'd20000000
`define CAL_PERIOD_S              33'd300
`define CAL_PERIOD_CYCLES         (`CAL_PERIOD_S * `CLK_HZ)
`endif

// ### verification/ahb_host.sv
// Bus master model standing in for the controller
`timescale 1ns/100ps
`default_nettype none
module ahb_host (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output var  logic        hsel,
    output var  logic [31:0] haddr,
    output var  logic [1:0]  htrans,
    output var  logic        hwrite,
    output var  logic [2:0]  hsize,
    output var  logic [31:0] hwdata,
    output var  logic        rd_seen,
    output var  logic [15:0] rd_value
);
    // Idle bus at time zero
    initial begin
        hsel     = 1'b0;
        haddr    = 32'h0;
        htrans   = 2'h0;
        hwrite   = 1'b0;
        hsize    = 3'h2;
        hwdata   = 32'h0;
        rd_seen  = 1'b0;
        rd_value = 16'h0;
    end
    // Wait for the edge where the slave is ready
    task automatic wait_ready;
        do @(posedge hclk); while (hready !== 1'b1);
    endtask
    // One single word transfer, entered just after a rising edge
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        haddr  <= ~a;
        hwdata <= wr ? d : ~hwdata;
        wait_ready();
        hwdata <= ~d;
        if (!wr) begin
            rd_seen  <= 1'b1;
            rd_value <= hrdata[15:0];
        end
    endtask
    // Result flag lasts one cycle
    always @(posedge hclk) begin
        if (rd_seen) begin
            rd_seen <= 1'b0;
        end
    end
endmodule // ahb_host
`default_nettype wire

// ### verification/thermo_checker_sva.sv
// Concurrent checks on the ports of the input image block
`timescale 1ns/100ps
`default_nettype none
`include "thermo_map.vh"
module thermo_checker #(
    parameter        CAL_W             = 33,
    parameter [32:0] CAL_PERIOD_CYCLES = 33'd20
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic [3:0]  channel_enable,
    input wire logic [63:0] active_setup,
    input wire logic [3:0]  setup_load,
    input wire logic        cal_request,
    input wire logic [3:0]  setup_error
);
    // ----
    // Helper logic
    // ----
    logic             take;
    logic             wr_setup;
    logic             cal_seen;
    logic [CAL_W-1:0] cal_gap;
    // Transfer taken, and a write to a channel setup word
    assign take     = hsel & hready & htrans[1];
    assign wr_setup = take & hwrite & haddr[6] & (haddr[5:4] == 2'h0);
    // Cycles since the last calibration pulse
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cal_seen <= 1'b0;
            cal_gap  <= '0;
        end else begin
            cal_seen <= cal_seen | cal_request;
            cal_gap  <= cal_request ? CAL_W'(1) : cal_gap + CAL_W'(1);
        end
    end
    // No spare code in any selection field
    function automatic logic legal(input logic [15:0] s);
        return (s[14:12] <= `FORMAT_LAST_VALID) && (s[11:8] <= `TYPE_LAST_VALID)
            && (s[2:0] != `FILTER_SPARE_A) && (s[2:0] != `FILTER_SPARE_B);
    endfunction
    // ----
    // Properties
    // ----
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_read(logic [4:0] w);
        take && !hwrite && (haddr[6:2] == w);
    endsequence
    sequence s_read_off;
        take && !hwrite && (haddr[6:4] == 3'h0) && !channel_enable[haddr[3:2]];
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not OKAY");
    a_upper_zero: assert property (take && !hwrite |=> hrdata[31:16] == 16'h0)
        else $error("upper half set");
    a_status_resv: assert property (s_read(5'h4) |=> hrdata[15:13] == 3'h0 && hrdata[7:5] == 3'h0)
        else $error("fault word reserved set");
    a_range_resv: assert property (s_read(5'h5) |=> hrdata[5:0] == 6'h0)
        else $error("range word reserved set");
    a_disabled_zero: assert property (s_read_off |=> hrdata == 32'h0)
        else $error("disabled reading set");
    a_load_source: assert property (setup_load != 4'h0 |-> $past(wr_setup, 2))
        else $error("load without write");
    a_err_source: assert property (setup_error != $past(setup_error) |-> $past(wr_setup, 2))
        else $error("error without write");
    a_load_no_err: assert property ((setup_load & setup_error) == 4'h0)
        else $error("load and error");
    a_enable_map: assert property (channel_enable == {active_setup[63], active_setup[47],
        active_setup[31], active_setup[15]})
        else $error("enable mismatch");
    a_active_legal: assert property (legal(active_setup[15:0]) && legal(active_setup[31:16])
        && legal(active_setup[47:32]) && legal(active_setup[63:48]))
        else $error("spare code active");
    a_cal_period: assert property (cal_request && cal_seen |-> cal_gap == CAL_PERIOD_CYCLES)
        else $error("cal period wrong");
    a_cal_pulse: assert property (cal_request |=> !cal_request)
        else $error("cal pulse long");
endmodule // thermo_checker
`default_nettype wire

// ### verification/thermo_input_image_status_config_bench.sv
// Self-checking bench of the input image block
`timescale 1ns/100ps
`default_nettype none
module thermo_input_image_status_config_bench;
    localparam int CAL = 20;
    logic        hclk            = 1'b0;
    logic        hresetn         = 1'b0;
    logic        conv_strobe     = 1'b0;
    logic [2:0]  conv_channel    = 3'h0;
    logic        conv_polarity   = 1'b0;
    logic [14:0] conv_magnitude  = 15'h0;
    logic        conv_wire_break = 1'b0;
    logic        conv_high_limit = 1'b0;
    logic        conv_low_limit  = 1'b0;
    logic [4:0]  hw_fault        = 5'h0;
    wire         hsel, hwrite, hreadyout, hresp, cal_request, rd_seen;
    wire  [31:0] haddr, hwdata, hrdata;
    wire  [1:0]  htrans;
    wire  [2:0]  hsize;
    wire  [3:0]  channel_enable, setup_load, setup_error;
    wire  [63:0] active_setup;
    wire  [15:0] rd_value;
    logic [15:0] q[$];
    int          bad_count  = 0;
    int          num_checks = 0;

    thermo_input_image_status_config #(.CAL_PERIOD_CYCLES(33'(CAL))) i_thermo_input_image_status_config (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
        .hresp, .hrdata, .conv_strobe, .conv_channel, .conv_polarity, .conv_magnitude, .conv_wire_break,
        .conv_high_limit, .conv_low_limit, .hw_fault, .channel_enable, .active_setup, .setup_load,
        .cal_request, .setup_error);
    ahb_host u_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .rd_seen(rd_seen),
        .rd_value(rd_value));

    // Clock, 50 ns period
    always #25 hclk = ~hclk;
    // ----
    // Tasks
    // ----
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h want %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish;
        if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] want);
        q.push_back(want);
        u_host.xfer(1'b0, {25'h0, a}, 32'h0);
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        u_host.xfer(1'b1, {25'h0, a}, {16'h0, d});
    endtask
    task automatic strobe(input logic [2:0] ch, input logic [15:0] v, input logic [2:0] fl);
        conv_channel <= ch;
        {conv_polarity, conv_magnitude} <= v;
        {conv_wire_break, conv_high_limit, conv_low_limit} <= fl;
        conv_strobe <= 1'b1;
        @(posedge hclk);
        conv_strobe    <= 1'b0;
        conv_magnitude <= ~v[14:0];
    endtask
    // Valid enabled setup word with format, type, open and filter fields differing per channel
    function automatic logic [15:0] good(input int c);
        return {1'b1, 3'(c), 4'(7 + c), 1'(c), 2'(c), 2'b00, 3'(3 + c)};
    endfunction
    // Compare each read result with the oldest note
    always @(posedge hclk) begin
        if (rd_seen === 1'b1) begin
            check(rd_value, q.pop_front());
        end
    end
    // Cut a hang short
    initial begin
        repeat (20000) @(posedge hclk);
        bad_count++;
        tally_and_finish();
    end
    // ----
    // Main sequence
    // ----
    initial begin
        logic [15:0] m;
        logic [15:0] cfg;
        logic [2:0]  fl;
        int          n;
        void'($urandom(25612));
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 7; i++) begin
            rd(7'(4 * i), 16'h0);
            rd(7'(64 + 4 * i), 16'h0);
        end
        wr(7'h00, 16'hffff);
        rd(7'h00, 16'h0);
        check(16'(channel_enable), 16'h0);
        for (int c = 0; c < 4; c++) begin
            wr(7'(64 + 4 * c), good(c));
            @(posedge hclk);
            check(16'(channel_enable), 16'((2 << c) - 1));
            rd(7'(64 + 4 * c), good(c));
            rd(7'h10, 16'(1 << c));
            m = 16'($urandom);
            strobe(3'(c), m, 3'h0);
            rd(7'(4 * c), m);
            rd(7'h10, 16'h0);
        end
        for (int c = 0; c < 5; c++) begin
            for (int f = 0; f < 3; f++) begin
                fl = 3'(1 << f);
                strobe(3'(c), 16'($urandom), fl);
                rd(7'h10, 16'(1 << c) | (16'(fl[2]) << (8 + c)));
                rd(7'h14, (16'(fl[1]) << (14 - 2 * c)) | (16'(fl[0]) << (15 - 2 * c)));
            end
            strobe(3'(c), 16'h0123, 3'h0);
            rd(7'h10, 16'h0);
            rd(7'h14, 16'h0);
            hw_fault <= 5'(1 << c);
            strobe(3'(c), 16'h0, 3'h0);
            hw_fault <= 5'h0;
            rd(7'h10, 16'(1 << c));
            strobe(3'(c), 16'h0, 3'h0);
            rd(7'h10, 16'h0);
        end
        for (int k = 0; k < 10; k++) begin
            cfg = 16'h8000 | (k < 3 ? 16'(5 + k) << 12 : k < 8 ? 16'(8 + k) << 8 : k < 9 ? 16'h2 : 16'h7);
            wr(7'h44, cfg);
            @(posedge hclk);
            check(16'(setup_error), 16'h2);
            check(active_setup[31:16], good(1));
            rd(7'h44, cfg);
            rd(7'h10, 16'h0);
        end
        rd(7'h18, 16'h2);
        wr(7'h44, good(1));
        @(posedge hclk);
        check(16'(setup_error), 16'h0);
        strobe(3'h1, 16'h0, 3'h0);
        wr(7'h50, 16'hffff);
        rd(7'h50, 16'h1);
        repeat (25) @(posedge hclk);
        n = 0;
        repeat (5 * CAL) begin
            @(posedge hclk);
            n += int'(cal_request === 1'b1);
        end
        check(16'(n), 16'h5);
        wr(7'h50, 16'h0);
        wr(7'h48, 16'h0);
        @(posedge hclk);
        check(16'(channel_enable), 16'hb);
        rd(7'h08, 16'h0);
        strobe(3'h2, 16'h7fff, 3'h7);
        rd(7'h08, 16'h0);
        rd(7'h10, 16'h0);
        rd(7'h14, 16'h0);
        repeat (3) @(posedge hclk);
        check(16'(q.size()), 16'h0);
        tally_and_finish();
    end
endmodule // thermo_input_image_status_config_bench

bind thermo_input_image_status_config thermo_checker #(
    .CAL_W(CAL_W), .CAL_PERIOD_CYCLES(CAL_PERIOD_CYCLES)
) u_checker (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
    .channel_enable, .active_setup, .setup_load, .cal_request, .setup_error);
`default_nettype wire
